// ===== src/dpsm_pkg.sv
// shared constants and types of the dual port serial mux
// assumes a single core clock and an active-low asynchronous reset
package dpsm_pkg;

   // ****************************************************
   // register port
   // ****************************************************
   localparam int ADDR_W = 4;             // function code width
   localparam logic [1:0] FN_STATUS = 2'h0; // 00xx read port status
   localparam logic [1:0] FN_DATA = 2'h1;   // 01xx read port data
   localparam logic [1:0] FN_PORT = 2'h2;   // 10xx port writes
   localparam logic [1:0] FN_CAL = 2'h3;    // 11xx calendar and dial
   localparam logic [3:0] ADDR_TXD0 = 4'h8; // transmit char, port 0
   localparam logic [3:0] ADDR_FMT0 = 4'ha; // line format, port 0
   localparam logic [3:0] ADDR_TOD = 4'hc;  // seconds of day
   localparam logic [3:0] ADDR_DATE = 4'hd; // month and year
   localparam logic [3:0] ADDR_DIAL = 4'he; // dial-out control, port 1

   // ****************************************************
   // line rates and timing
   // ****************************************************
   localparam int BAUD_110 = 110;
   localparam int BAUD_300 = 300;
   localparam int BAUD_600 = 600;
   localparam int BAUD_1200 = 1200;
   localparam int BAUD_2400 = 2400;
   localparam int BAUD_4800 = 4800;
   localparam int BAUD_9600 = 9600;
   localparam int BAUD_19200 = 19200;
   localparam int CLK_HZ_DEF = 100_000_000; // core clock rate
   localparam int BITCNT_W = 20;            // holds the 110 baud bit time
   localparam logic [7:0] SW_POLL_CYC = 8'hff; // switch receiver poll period
   localparam logic [16:0] TOD_LAST = 17'h1517f; // 86399 seconds

   // ****************************************************
   // switch codes and buffers
   // ****************************************************
   localparam logic [2:0] OPT_DISABLED = 3'h7;
   localparam logic [2:0] OPT_MESSAGES_ONLY_OPTION = 3'h6;
   localparam logic [2:0] OPT_BOOT = 3'h5;
   localparam logic [2:0] OPT_BOOT_PWR = 3'h3;
   localparam int TXQ_AW = 6;               // 64 character output buffer
   localparam logic [1:0] RXQ_DEPTH = 2'h3; // three character input buffer
   localparam logic [2:0] BAUD_SW_RST = 3'h7;
   localparam logic [2:0] OPT_SW_RST = 3'h7;

   // ****************************************************
   // types
   // ****************************************************
   typedef struct packed {
      logic [1:0] len;     // data bits minus five
      logic par_en;        // parity bit present
      logic par_odd;       // odd when set, even when clear
      logic stop2;         // two stop bits
   } dpsm_fmt_t;
   localparam dpsm_fmt_t FMT_RST = 5'h18; // 8 bits, no parity, 1 stop

   typedef struct packed {
      logic framing_err;   // sticky
      logic parity_err;    // sticky
      logic overrun;       // sticky
      logic tx_busy;
      logic txq_empty;
      logic txq_full;
      logic rx_avail;
   } dpsm_stat_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PAR = 3'b011,
      TX_STOP = 3'b100
   } dpsm_tx_st_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PAR = 3'b011,
      RX_STOP = 3'b100
   } dpsm_rx_st_t;

endpackage : dpsm_pkg

// ===== src/dpsm_mux.sv
// dual port serial mux: two framed serial ports behind a function port
// assumes switch and serial pins are asynchronous; the host port is on core_clk
// Behaviour
// - start, 5-8 data, parity, 1-2 stops
// - software sets length, parity, stop count
// - each port has its own rate
// - three-bit switch code selects rate
// - rate switch read on decoder strobe
// - option switch read on decoder strobe
// - option code disables or grants remote functions
// - switch values never reach host reads
// - 64 character output, 3 character input
// - characters are seven-bit ascii only
// - output queue decouples host from line
// - uart serialises and deserialises each port
// - function codes decoded and carried out
// - output queue feeds the transmitter
// - port data steered onto host bus
// - 00xx returns status, 01xx returns data
// - host reaches mux only via this port
// - port 0 console, port 1 maintenance
// - dial-out only on port 1
// - calendar of time, month, year
//
// Chosen here: the address-and-strobe port and the register offsets.
module dpsm_mux
   import dpsm_pkg::*;
#(
   parameter int CLK_HZ = CLK_HZ_DEF
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // host function port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // rotary switch pins, per port
   input wire logic [2:0] baud_sw [2],
   input wire logic [2:0] opt_sw [2],
   // serial lines, port 0 console, port 1 maintenance
   input wire logic [1:0] rxd,
   output logic [1:0] txd,
   // option grants, per port
   output logic [1:0] port_en,
   output logic [1:0] remote_boot_en,
   output logic [1:0] remote_power_en,
   // dial-out pins, port 1 only
   output logic dial_call_req,
   output logic dial_digit_present,
   output logic [3:0] dial_digit
);

   // ****************************************************
   // rate table
   // ****************************************************

   // bit time in cycles; rounded down from the exact figure
   // code to rate
   function automatic logic [BITCNT_W-1:0] bit_cyc(input logic [2:0] c);
      case (c)
         3'h7: bit_cyc = BITCNT_W'(CLK_HZ / BAUD_110);
         3'h6: bit_cyc = BITCNT_W'(CLK_HZ / BAUD_300);
         3'h5: bit_cyc = BITCNT_W'(CLK_HZ / BAUD_600);
         3'h4: bit_cyc = BITCNT_W'(CLK_HZ / BAUD_1200);
         3'h3: bit_cyc = BITCNT_W'(CLK_HZ / BAUD_2400);
         3'h2: bit_cyc = BITCNT_W'(CLK_HZ / BAUD_4800);
         3'h1: bit_cyc = BITCNT_W'(CLK_HZ / BAUD_9600);
         default: bit_cyc = BITCNT_W'(CLK_HZ / BAUD_19200);
      endcase
   endfunction : bit_cyc

   // ****************************************************
   // switch receivers
   // ****************************************************
   logic [7:0] poll_r;            // internal decoder-one poll timer
   logic sw_sel;                  // decoder one with memory read
   logic [2:0] baud_m [2];        // first sync stage, read only by baud_s
   logic [2:0] baud_s [2];
   logic [2:0] opt_m [2];
   logic [2:0] opt_s [2];
   logic [2:0] baud_r [2];        // held rate code
   logic [2:0] opt_r [2];         // held option code

   // poll timer stands in for the microprocessor's periodic read
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         poll_r <= 8'h00;
      end else if (sw_sel) begin
         poll_r <= 8'h00;
      end else begin
         poll_r <= poll_r + 8'h01;
      end
   end
   assign sw_sel = (poll_r == SW_POLL_CYC);

   // ****************************************************
   // calendar and dial
   // ****************************************************
   logic [26:0] tick_r;           // one second prescaler
   logic [16:0] tod_r;            // seconds of day
   logic [3:0] month_r;
   logic [7:0] year_r;            // years past a software chosen base
   logic [5:0] dial_r;            // digit present, digit, call request
   logic wr_tod;
   logic wr_date;
   logic wr_dial;

   assign wr_tod = wr && (addr == ADDR_TOD);
   assign wr_date = wr && (addr == ADDR_DATE);
   assign wr_dial = wr && (addr == ADDR_DIAL);

   // time of day counts; month and year only change by host write
   // calendar keeping
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_r <= 27'h0;
         tod_r <= 17'h0;
      end else if (wr_tod) begin
         tick_r <= 27'h0;
         tod_r <= wdata[16:0];
      end else if (tick_r == 27'(CLK_HZ - 1)) begin
         tick_r <= 27'h0;
         tod_r <= (tod_r == TOD_LAST) ? 17'h0 : tod_r + 17'h1;
      end else begin
         tick_r <= tick_r + 27'h1;
      end
   end

   // date register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         month_r <= 4'h1;
         year_r <= 8'h0;
      end else if (wr_date) begin
         month_r <= wdata[11:8];
         year_r <= wdata[7:0];
      end
   end

   // dial control, held off while port 1 is switched off
   // port one only, port roles
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dial_r <= 6'h0;
      end else if (!port_en[1]) begin
         dial_r <= 6'h0;
      end else if (wr_dial) begin
         dial_r <= wdata[5:0];
      end
   end
   assign dial_call_req = dial_r[0];
   assign dial_digit = dial_r[4:1];
   assign dial_digit_present = dial_r[5];

   // ****************************************************
   // per port logic
   // ****************************************************
   dpsm_stat_t stat [2];           // per port status word
   logic [6:0] rx_head [2];        // oldest received character
   dpsm_fmt_t fmt_r [2];           // programmed line format

   genvar gv;
   generate
      for (gv = 0; gv < 2; gv++) begin : g_port
         logic [6:0] txq [64];         // output buffer
         logic [TXQ_AW:0] wp_r;        // write pointer with wrap bit
         logic [TXQ_AW:0] rp_r;        // read pointer with wrap bit
         logic q_full;
         logic q_empty;
         logic q_push;
         logic q_pop;
         dpsm_tx_st_t tx_st_r;
         logic [BITCNT_W-1:0] tx_cnt_r;
         logic [7:0] tx_sh_r;          // shift register, lsb first
         logic [2:0] tx_bit_r;         // bits sent in current field
         logic tx_par_r;
         logic rx_m;                   // first sync stage
         logic rx_s;
         dpsm_rx_st_t rx_st_r;
         logic [BITCNT_W-1:0] rx_cnt_r;
         logic [7:0] rx_sh_r;
         logic [2:0] rx_bit_r;
         logic rx_par_r;
         logic rx_push;
         logic rx_pop;
         logic [6:0] rxq [3];          // input buffer
         logic [1:0] rxq_cnt_r;
         logic ovr_r;
         logic perr_r;
         logic ferr_r;
         logic stat_rd;
         logic [2:0] nbits;            // data bits minus one
         logic en;
         logic [BITCNT_W-1:0] full_cyc;

         assign en = port_en[gv];
         assign full_cyc = bit_cyc(baud_r[gv]);
         assign nbits = 3'h4 + {1'b0, fmt_r[gv].len};

         // switch sync and hold; each port keeps its own codes
         // independent rate, rate read on strobe
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               baud_m[gv] <= BAUD_SW_RST;
               baud_s[gv] <= BAUD_SW_RST;
               opt_m[gv] <= OPT_SW_RST;
               opt_s[gv] <= OPT_SW_RST;
               baud_r[gv] <= BAUD_SW_RST;
               opt_r[gv] <= OPT_SW_RST;
            end else begin
               baud_m[gv] <= baud_sw[gv];
               baud_s[gv] <= baud_m[gv];
               opt_m[gv] <= opt_sw[gv];
               opt_s[gv] <= opt_m[gv];
               if (sw_sel) begin
                  baud_r[gv] <= baud_s[gv];
                  opt_r[gv] <= opt_s[gv];
               end
            end
         end

         // option decode; unlisted codes behave as messages only
         // option grants
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               port_en[gv] <= 1'b0;
               remote_boot_en[gv] <= 1'b0;
               remote_power_en[gv] <= 1'b0;
            end else begin
               port_en[gv] <= (opt_r[gv] != OPT_DISABLED);
               remote_boot_en[gv] <= (opt_r[gv] == OPT_BOOT) || (opt_r[gv] == OPT_BOOT_PWR);
               remote_power_en[gv] <= (opt_r[gv] == OPT_BOOT_PWR);
            end
         end

         // line format written by the host
         // programmable format
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               fmt_r[gv] <= FMT_RST;
            end else if (wr && (addr == ADDR_FMT0 + 4'(gv))) begin
               fmt_r[gv] <= wdata[4:0];
            end
         end

         // output queue; writes to a full or disabled port are dropped
         // 64 deep, host not throttled, ascii
         assign q_full = (wp_r[TXQ_AW] != rp_r[TXQ_AW]) &&
                         (wp_r[TXQ_AW-1:0] == rp_r[TXQ_AW-1:0]);
         assign q_empty = (wp_r == rp_r);
         assign q_push = wr && (addr == ADDR_TXD0 + 4'(gv)) && !q_full && en;
         assign q_pop = (tx_st_r == TX_IDLE) && !q_empty && en;
         always_ff @(posedge core_clk) begin
            if (q_push) begin
               txq[wp_r[TXQ_AW-1:0]] <= wdata[6:0];
            end
         end
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               wp_r <= '0;
               rp_r <= '0;
            end else begin
               if (q_push) begin
                  wp_r <= wp_r + 7'h1;
               end
               if (q_pop) begin
                  rp_r <= rp_r + 7'h1;
               end
            end
         end

         // transmitter: start, data lsb first, parity, stops
         // queue feeds uart, serialise, framing
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               tx_st_r <= TX_IDLE;
               tx_cnt_r <= '0;
               tx_sh_r <= 8'h00;
               tx_bit_r <= 3'h0;
               tx_par_r <= 1'b0;
               txd[gv] <= 1'b1;
            end else if (tx_st_r == TX_IDLE) begin
               txd[gv] <= 1'b1;
               if (q_pop) begin
                  tx_sh_r <= {1'b0, txq[rp_r[TXQ_AW-1:0]]};
                  tx_par_r <= fmt_r[gv].par_odd;
                  tx_cnt_r <= full_cyc - 20'h1;
                  tx_bit_r <= 3'h0;
                  tx_st_r <= TX_START;
                  txd[gv] <= 1'b0;
               end
            end else if (tx_cnt_r != '0) begin
               tx_cnt_r <= tx_cnt_r - 20'h1;
            end else begin
               tx_cnt_r <= full_cyc - 20'h1;
               case (tx_st_r)
                  TX_START, TX_DATA: begin
                     if (tx_st_r == TX_DATA && tx_bit_r == nbits) begin
                        // last data bit done
                        tx_st_r <= fmt_r[gv].par_en ? TX_PAR : TX_STOP;
                        txd[gv] <= fmt_r[gv].par_en ? tx_par_r : 1'b1;
                        tx_bit_r <= 3'h0;
                     end else begin
                        if (tx_st_r == TX_DATA) begin
                           tx_bit_r <= tx_bit_r + 3'h1;
                        end
                        tx_st_r <= TX_DATA;
                        txd[gv] <= tx_sh_r[0];
                        tx_par_r <= tx_par_r ^ tx_sh_r[0];
                        tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                     end
                  end
                  TX_PAR: begin
                     tx_st_r <= TX_STOP;
                     txd[gv] <= 1'b1;
                  end
                  TX_STOP: begin
                     // second stop bit when asked for
                     if (fmt_r[gv].stop2 && tx_bit_r == 3'h0) begin
                        tx_bit_r <= 3'h1;
                     end else begin
                        tx_st_r <= TX_IDLE;
                     end
                  end
                  default: begin
                     tx_st_r <= TX_IDLE;
                     txd[gv] <= 1'b1;
                  end
               endcase
            end
         end

         // receive line synchroniser
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               rx_m <= 1'b1;
               rx_s <= 1'b1;
            end else begin
               rx_m <= rxd[gv];
               rx_s <= rx_m;
            end
         end

         // receiver; half a bit after the start edge, then whole bits
         // centre sampling, deserialise, ignore when off
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               rx_st_r <= RX_IDLE;
               rx_cnt_r <= '0;
               rx_sh_r <= 8'h00;
               rx_bit_r <= 3'h0;
               rx_par_r <= 1'b0;
            end else if (!en) begin
               rx_st_r <= RX_IDLE;
            end else if (rx_st_r == RX_IDLE) begin
               if (!rx_s) begin
                  rx_st_r <= RX_START;
                  rx_cnt_r <= {1'b0, full_cyc[BITCNT_W-1:1]};
               end
            end else if (rx_cnt_r != '0) begin
               rx_cnt_r <= rx_cnt_r - 20'h1;
            end else begin
               rx_cnt_r <= full_cyc - 20'h1;
               case (rx_st_r)
                  RX_START: begin
                     // a glitch shorter than half a bit is dropped
                     rx_st_r <= rx_s ? RX_IDLE : RX_DATA;
                     rx_bit_r <= 3'h0;
                     rx_sh_r <= 8'h00;
                     rx_par_r <= fmt_r[gv].par_odd;
                  end
                  RX_DATA: begin
                     rx_sh_r[rx_bit_r] <= rx_s;
                     rx_par_r <= rx_par_r ^ rx_s;
                     rx_bit_r <= rx_bit_r + 3'h1;
                     if (rx_bit_r == nbits) begin
                        rx_st_r <= fmt_r[gv].par_en ? RX_PAR : RX_STOP;
                     end
                  end
                  RX_PAR: begin
                     rx_par_r <= rx_par_r ^ rx_s;
                     rx_st_r <= RX_STOP;
                  end
                  default: begin
                     rx_st_r <= RX_IDLE;
                  end
               endcase
            end
         end
         // one stop bit is checked; the second is idle line anyway
         assign rx_push = en && (rx_st_r == RX_STOP) && (rx_cnt_r == '0) && rx_s;
         assign rx_pop = rd && (addr[3:2] == FN_DATA) && (addr[0] == 1'(gv));

         // input buffer, three deep; bit 7 dropped for ascii
         // three deep, ascii
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               rxq_cnt_r <= 2'h0;
               rxq[0] <= 7'h00;
               rxq[1] <= 7'h00;
               rxq[2] <= 7'h00;
            end else if (rx_pop && rxq_cnt_r != 2'h0) begin
               rxq[0] <= rxq[1];
               rxq[1] <= rxq[2];
               if (rx_push) begin
                  rxq[rxq_cnt_r - 2'h1] <= rx_sh_r[6:0];
               end else begin
                  rxq_cnt_r <= rxq_cnt_r - 2'h1;
               end
            end else if (rx_push && rxq_cnt_r != RXQ_DEPTH) begin
               rxq[rxq_cnt_r] <= rx_sh_r[6:0];
               rxq_cnt_r <= rxq_cnt_r + 2'h1;
            end
         end

         // sticky errors; a new error in the clearing read wins
         assign stat_rd = rd && (addr[3:2] == FN_STATUS) && (addr[0] == 1'(gv));
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               ovr_r <= 1'b0;
               perr_r <= 1'b0;
               ferr_r <= 1'b0;
            end else begin
               ovr_r <= (rx_push && rxq_cnt_r == RXQ_DEPTH && !rx_pop) ||
                        (ovr_r && !stat_rd);
               perr_r <= (rx_push && fmt_r[gv].par_en && rx_par_r) ||
                         (perr_r && !stat_rd);
               ferr_r <= (en && rx_st_r == RX_STOP && rx_cnt_r == '0 && !rx_s) ||
                         (ferr_r && !stat_rd);
            end
         end

         // status carries no switch value
         // switches hidden
         assign stat[gv] = '{framing_err: ferr_r, parity_err: perr_r, overrun: ovr_r,
                             tx_busy: (tx_st_r != TX_IDLE), txq_empty: q_empty,
                             txq_full: q_full, rx_avail: (rxq_cnt_r != 2'h0)};
         assign rx_head[gv] = rxq[0];
      end
   endgenerate

   // ****************************************************
   // read answer
   // ****************************************************

   // function decode; answer valid the cycle after the strobe only
   // function decode, status and data codes
   // port data to host bus, sole host path
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0;
      end else if (!rd) begin
         rdata <= 32'h0;
      end else begin
         case (addr[3:2])
            FN_STATUS: rdata <= {25'h0, stat[addr[0]]};
            FN_DATA: rdata <= {25'h0, rx_head[addr[0]]};
            FN_PORT: rdata <= addr[1] ? {27'h0, fmt_r[addr[0]]} : 32'h0;
            default: begin
               case (addr)
                  ADDR_TOD: rdata <= {15'h0, tod_r};
                  ADDR_DATE: rdata <= {20'h0, month_r, year_r};
                  ADDR_DIAL: rdata <= {26'h0, dial_r};
                  default: rdata <= 32'h0;
               endcase
            end
         endcase
      end
   end

endmodule : dpsm_mux

// ===== test/dpsm_monitor.sv
// port checker for the dual port serial mux
// assumes it is bound to dpsm_mux and sees only its ports
module dpsm_monitor
   import dpsm_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // host port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // line and grant pins
   input wire logic [1:0] txd,
   input wire logic [1:0] port_en,
   input wire logic [1:0] remote_boot_en,
   input wire logic [1:0] remote_power_en,
   input wire logic dial_call_req,
   input wire logic [3:0] dial_digit
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ****************************************************
   // properties
   // ****************************************************
   property p_rd_gap; !$past(rd) |-> rdata == 32'h0; endproperty
   property p_unmapped; rd && addr == 4'hf |=> rdata == 32'h0; endproperty
   // power needs boot, boot needs an enabled port
   property p_grant;
      ((remote_power_en & ~remote_boot_en) | (remote_boot_en & ~port_en)) == 2'h0;
   endproperty
   property p_dial_off; !port_en[1] && !$past(port_en[1]) |-> !dial_call_req; endproperty
   // start bit is never a short glitch
   property p_start0; $fell(txd[0]) |=> !txd[0] [*8]; endproperty
   property p_start1; $fell(txd[1]) |=> !txd[1] [*8]; endproperty
   property p_fmt;
      wr && addr == ADDR_FMT0 ##1 rd && addr == ADDR_FMT0 |=> rdata[4:0] == $past(wdata[4:0], 2);
   endproperty
   property p_dial;
      wr && addr == ADDR_DIAL && port_en[1] |=> dial_digit == $past(wdata[4:1]);
   endproperty
   a_rd_gap: assert property (p_rd_gap) else $error("rdata outside read slot");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_grant: assert property (p_grant) else $error("option grants inconsistent");
   a_dial_off: assert property (p_dial_off) else $error("dial while port off");
   a_start0: assert property (p_start0) else $error("short start bit port 0");
   a_start1: assert property (p_start1) else $error("short start bit port 1");
   a_fmt: assert property (p_fmt) else $error("format readback wrong");
   a_dial: assert property (p_dial) else $error("dial digit wrong");
   c_rx: cover property (rd && addr == 4'h4);
   c_dial: cover property (wr && addr == ADDR_DIAL);
   c_tx1: cover property ($fell(txd[1]));
endmodule : dpsm_monitor

// ===== test/dpsm_term.sv
// echoing serial terminal, 8 data bits, no parity, one stop
// assumes a fixed bit time in core clock cycles
module dpsm_term #(
   parameter int BIT = 100
) (
   // clock
   input wire logic core_clk,
   // serial pair
   input wire logic from_dev,
   output logic to_dev
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] frm; // start, data, stop
   initial to_dev = 1'b1; // idle mark, never released
   // hear one ascii frame, send it back
   always begin
      @(negedge from_dev);
      repeat (BIT / 2) @(posedge core_clk);
      frm = 10'h200;
      for (int i = 1; i < 9; i++) begin
         repeat (BIT) @(posedge core_clk);
         frm[i] = from_dev;
      end
      repeat (BIT * 2) @(posedge core_clk);
      for (int i = 0; i < 10; i++) begin
         to_dev <= frm[i];
         repeat (BIT) @(posedge core_clk);
      end
   end
endmodule : dpsm_term

// ===== test/tb_top.sv
// self-checking bench for the dual port serial mux
// assumes dpsm_term echoes each port, 1920000 hz bit timing base
module tb_top;
   import dpsm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst_n, wr, rd;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [2:0] baud_sw [2];
   logic [2:0] opt_sw [2];
   logic [1:0] rxd, txd, port_en, boot_en, pwr_en;
   logic call, present;
   logic [3:0] digit;
   int n_errors = 0;
   int compares = 0;
   // port 1 option codes and expected {en, boot, power} of both ports
   logic [2:0] codes [4] = '{3'h7, 3'h5, 3'h3, 3'h6};
   logic [5:0] grants [4] = '{6'h15, 6'h3d, 6'h3f, 6'h35};
   always #5 core_clk = ~core_clk;
   dpsm_mux #(.CLK_HZ(1920000)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .baud_sw(baud_sw), .opt_sw(opt_sw),
      .rxd(rxd), .txd(txd), .port_en(port_en), .remote_boot_en(boot_en),
      .remote_power_en(pwr_en), .dial_call_req(call), .dial_digit_present(present),
      .dial_digit(digit));
   // 19200 baud on port 0, 9600 on port 1
   dpsm_term #(.BIT(100)) u_t0 (.core_clk(core_clk), .from_dev(txd[0]), .to_dev(rxd[0]));
   dpsm_term #(.BIT(200)) u_t1 (.core_clk(core_clk), .from_dev(txd[1]), .to_dev(rxd[1]));
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask : wr_reg
   // data stand one cycle after the strobe, sampled mid-cycle
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      @(negedge core_clk);
      v = rdata;
      @(posedge core_clk);
   endtask : rd_reg
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // poll status until a character waits, bounded
   task automatic wait_rx(input logic [3:0] a);
      for (int n = 0; n < 100; n++) begin
         rd_reg(a, d);
         if (d[0] === 1'b1) break;
         repeat (98) @(posedge core_clk);
      end
      chk("status", 32'h5, d & 32'h7f);
   endtask : wait_rx
   task automatic give_verdict;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      core_clk = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 32'h0;
      baud_sw[0] = 3'h0; baud_sw[1] = 3'h1; opt_sw[0] = 3'h3; opt_sw[1] = 3'h7;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         opt_sw[1] <= codes[i];
         repeat (600) @(posedge core_clk);
         chk("grants", {26'h0, grants[i]}, {26'h0, port_en, boot_en, pwr_en});
      end
      $display("options test done");
      wr_reg(ADDR_TXD0, 32'h41);
      wait_rx(4'h0);
      rd_reg(4'h4, d);
      chk("rx0", 32'h41, d);
      wr_reg(4'h9, 32'h5a);
      wait_rx(4'h1);
      rd_reg(4'h5, d);
      chk("rx1", 32'h5a, d);
      $display("echo test done");
      wr_reg(ADDR_FMT0, 32'h7);
      rd_reg(ADDR_FMT0, d);
      chk("format", 32'h7, d);
      wr_reg(ADDR_DATE, 32'hc63);
      rd_reg(ADDR_DATE, d);
      chk("date", 32'hc63, d);
      rd_reg(4'hf, d);
      chk("unmapped", 32'h0, d);
      $display("register test done");
      wr_reg(ADDR_DIAL, 32'h2b);
      opt_sw[1] <= 3'h7;
      @(negedge core_clk);
      chk("dial", 32'h2b, {26'h0, present, digit, call});
      repeat (600) @(posedge core_clk);
      chk("dial off", 32'h0, {31'h0, call});
      $display("dial test done");
      give_verdict();
   end
   // watchdog, about four times the expected run
   initial begin
      repeat (40000) @(posedge core_clk);
      n_errors++;
      give_verdict();
   end
endmodule : tb_top
bind dpsm_mux dpsm_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .txd(txd), .port_en(port_en),
   .remote_boot_en(remote_boot_en), .remote_power_en(remote_power_en),
   .dial_call_req(dial_call_req), .dial_digit(dial_digit));
